/* dv/ebp_chk_asserts.sv */
// Purpose: bus timing and control mirror checks for the pattern block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   lock and interrupt state are judged by the bench instead
`timescale 1ns/1ps
`default_nettype none
module ebp_chk
   import ebp_pkg::*;
(
   // clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // write channels
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic              awvalid,
   input wire logic              awready,
   input wire logic [31:0]       wdata,
   input wire logic [3:0]        wstrb,
   input wire logic              wvalid,
   input wire logic              wready,
   input wire logic [1:0]        bresp,
   input wire logic              bvalid,
   input wire logic              bready,
   // read channels
   input wire logic              arvalid,
   input wire logic              arready,
   input wire logic [31:0]       rdata,
   input wire logic              rvalid,
   input wire logic              rready,
   // streams and controls
   input wire logic              tx_bit_en,
   input wire logic              tx_line_data,
   input wire logic              rx_bit_en,
   input wire logic              rx_bp_data,
   input wire logic              tx_framer_skip,
   input wire logic              rx_framer_skip,
   input wire logic              defect_detect_on,
   input wire logic              irq
);
   logic [ADDR_W-1:0] aw_q, aw_d;
   logic [8:0]        wd_q, wd_d;

   // remember the last accepted write so its effect can be judged
   always_comb begin
      aw_d = (awvalid && awready) ? awaddr : aw_q;
      wd_d = (wvalid && wready) ? {wstrb[0], wdata[7:0]} : wd_q;
   end
   always_ff @(posedge aclk) begin
      aw_q <= aw_d;
      wd_q <= wd_d;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped early");
   wr_refuse_a: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");
   wr_latency_a: assert property
      (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response timing wrong");
   rd_latency_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   line_hold_a: assert property (!tx_bit_en |=> $stable(tx_line_data))
      else $error("line output moved without strobe");
   bp_hold_a: assert property (!rx_bit_en |=> $stable(rx_bp_data))
      else $error("backplane output moved without strobe");
   // a mapped write commits by the time its response rises
   skip_mirror_a: assert property ($rose(bvalid) && wd_q[8] &&
      aw_q[11:2] == {2'h0, IDX_PAT} |=> {rx_framer_skip, tx_framer_skip}
      == wd_q[1:0]) else $error("bypass outputs differ from register");
   defect_mirror_a: assert property ($rose(bvalid) && wd_q[8] &&
      aw_q[11:2] == {2'h0, IDX_DDE} |=> defect_detect_on == wd_q[7])
      else $error("defect enable differs from register");
   resp_code_a: assert property
      ($rose(bvalid) |-> bresp == (ebp_mapped(aw_q) ? RESP_OKAY : RESP_SLVERR))
      else $error("write response code wrong");
   reset_vals_a: assert property (disable iff (1'b0)
      !aresetn |=> defect_detect_on && !tx_framer_skip && !rx_framer_skip)
      else $error("control outputs wrong after reset");

   // main scenarios reached
   cover property ($rose(irq));
   cover property (bvalid && bresp == RESP_SLVERR);
   cover property (tx_bit_en && rx_bit_en ##1 tx_bit_en && rx_bit_en);
endmodule : ebp_chk

bind ebp_bert_ctrl ebp_chk u_ebp_chk (
   .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
   .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .tx_bit_en(tx_bit_en), .tx_line_data(tx_line_data),
   .rx_bit_en(rx_bit_en), .rx_bp_data(rx_bp_data),
   .tx_framer_skip(tx_framer_skip), .rx_framer_skip(rx_framer_skip),
   .defect_detect_on(defect_detect_on), .irq(irq));
`default_nettype wire

/* dv/testbench.sv */
// Purpose: register and pattern stream tests for the pattern block
// Assumes: strobes every cycle, streams looped back by the bench
// Notes:   bench checker tracks the pattern recurrence on its own
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   failures++; $display("unexpected at %0t: got %h exp %h", \
   $time, (g), (e)); end end
module testbench import ebp_pkg::*;;
   logic              aclk, aresetn;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0]       wdata, rdata, rd_d;
   logic [3:0]        wstrb;
   logic [1:0]        bresp, rresp, rsp;
   logic              awvalid, awready, wvalid, wready, bvalid, bready;
   logic              arvalid, arready, rvalid, rready, irq;
   logic              tx_bit_en, tx_bp_data, tx_line_data, rx_bit_en;
   logic              rx_line_data, rx_bp_data, defect_detect_on;
   logic              tx_framer_skip, rx_framer_skip;
   logic              run_on, loop_on, mon_sw, mon_inv, mon_typ, mb, mp;
   logic [19:0]       hist;
   int                failures, total_checks, errs, nbits, i;

   ebp_bert_ctrl u_ebp_bert_ctrl (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tx_bit_en(tx_bit_en), .tx_bp_data(tx_bp_data),
      .tx_line_data(tx_line_data), .rx_bit_en(rx_bit_en),
      .rx_line_data(rx_line_data), .rx_bp_data(rx_bp_data),
      .tx_framer_skip(tx_framer_skip), .rx_framer_skip(rx_framer_skip),
      .defect_detect_on(defect_detect_on), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // strobes each cycle while run_on is set; loop off feeds alternating bits, never a pattern
   // held low in reset so the toggles start from a known level
   always @(posedge aclk) begin
      tx_bit_en    <= run_on;
      rx_bit_en    <= run_on;
      rx_line_data <= aresetn && (loop_on ? tx_line_data : ~rx_line_data);
      tx_bp_data   <= aresetn && (loop_on ? rx_bp_data : ~tx_bp_data);
   end

   // self-synchronising check of the generated stream, after warm-up
   always @(posedge aclk) begin
      if (tx_bit_en) begin
         #1;
         mb = (mon_sw ? rx_bp_data : tx_line_data) ^ mon_inv;
         mp = mon_typ ? (hist[19] ^ hist[16]) : (hist[14] ^ hist[13]);
         if (nbits >= 20 && mb !== mp)
            errs++;
         hist = {hist[18:0], mb};
         nbits++;
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt

   task automatic settle();
      wt(40);
      errs  = 0;
      nbits = 0;
      wt(120);
   endtask : settle

   task automatic axw(input logic [7:0] idx, input logic [7:0] d);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d  = 1'b0;
      @(posedge aclk);
      awaddr  <= {2'h0, idx, 2'h0};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (awready && !aw_d) begin
            aw_d = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_d) begin
            w_d = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // ready raised late so the hold checks see a stalled answer
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] idx);
      @(posedge aclk);
      araddr  <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rd_d = rdata;
      rsp  = rresp;
      rready <= 1'b0;
   endtask : axr

   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      axr(idx);
      `CHK(rd_d, {24'h0, e})
      `CHK(rsp, RESP_OKAY)
   endtask : rdc

   task automatic results();
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      results();
   end

   initial begin
      {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
      {arvalid, rready, run_on, loop_on} = '0;
      {mon_sw, mon_inv, mon_typ, hist} = '0;
      wstrb = 4'hf;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      `CHK({defect_detect_on, rx_framer_skip, tx_framer_skip}, 3'h4)
      rdc(IDX_PAT, PAT_RST);
      rdc(IDX_SWAP, SWAP_RST);
      rdc(IDX_DDE, DDE_RST);
      // loop-code places are reserved: writes vanish
      for (i = 0; i < 4; i++) begin
         axw(IDX_LCC + 8'(i), 8'hff);
         rdc(IDX_LCC + 8'(i), 8'h00);
      end
      axr(8'h30);
      `CHK(rsp, RESP_SLVERR)
      axw(8'h30, 8'hff);
      `CHK(rsp, RESP_SLVERR)
      axw(IDX_PAT, 8'h13);
      rdc(IDX_PAT, 8'h03);
      `CHK({rx_framer_skip, tx_framer_skip}, 2'h3)
      axw(IDX_DDE, 8'h00);
      `CHK(defect_detect_on, 1'b0)
      axw(IDX_DDE, 8'h80);
      // a write with lane 0 off must leave the fields alone
      wstrb <= 4'he;
      axw(IDX_DDE, 8'h00);
      wstrb <= 4'hf;
      `CHK(rsp, RESP_OKAY)
      `CHK(defect_detect_on, 1'b1)
      axw(IDX_PAT, 8'h00);
      `CHK({rx_framer_skip, tx_framer_skip}, 2'h0)
      // every pattern type and polarity, line loopback
      run_on  <= 1'b1;
      loop_on <= 1'b1;
      for (i = 0; i < 4; i++) begin
         mon_typ = i[1];
         mon_inv = i[0];
         axw(IDX_PAT, {i[1], 1'b0, i[0], 5'h0c});
         settle();
         `CHK(errs, 0)
         rdc(IDX_PAT, {i[1], 1'b0, i[0], 5'h1c});
      end
      // lock loss event, masking and clearing
      axw(IDX_IST, 8'h03);
      rdc(IDX_IST, 8'h00);
      loop_on <= 1'b0;
      wt(100);
      rdc(IDX_IST, 8'h02);
      rdc(IDX_PAT, 8'hac);
      `CHK(irq, 1'b0)
      axw(IDX_IMK, 8'h02);
      rdc(IDX_IMK, 8'h02);
      `CHK(irq, 1'b1)
      axw(IDX_IST, 8'h02);
      `CHK(irq, 1'b0)
      // swapped direction: backplane loopback
      {mon_typ, mon_inv, mon_sw} = 3'h1;
      axw(IDX_PAT, 8'h0c);
      axw(IDX_SWAP, 8'h08);
      loop_on <= 1'b1;
      settle();
      `CHK(errs, 0)
      rdc(IDX_SWAP, 8'h08);
      rdc(IDX_PAT, 8'h1c);
      loop_on <= 1'b0;
      wt(100);
      rdc(IDX_PAT, 8'h0c);
      // one gain and one loss since the last clear
      rdc(IDX_IST, 8'h03);
      `CHK(irq, 1'b1)
      // single error: one flipped bit shows as three recurrence misses
      axw(IDX_SWAP, 8'h00);
      mon_sw = 1'b0;
      loop_on <= 1'b1;
      settle();
      axw(IDX_PAT, 8'h4c);
      wt(60);
      `CHK(errs, 3)
      axw(IDX_PAT, 8'h4c);
      wt(60);
      `CHK(errs, 3)
      axw(IDX_PAT, 8'h0c);
      wt(60);
      `CHK(errs, 3)
      // generator off: line carries backplane bits again
      loop_on <= 1'b0;
      axw(IDX_PAT, 8'h00);
      wt(3);
      #1;
      `CHK(tx_line_data, ~tx_bp_data)
      results();
   end
endmodule : testbench
`default_nettype wire

/* rtl/ebp_bert_ctrl.sv */
// Purpose: pattern test control/status with AXI4-Lite registers
// Assumes: bit strobes synchronous to aclk, one bit per strobe
// Notes:   one generator and one checker, steered by the swap bit
`timescale 1ns/1ps
`default_nettype none
module ebp_bert_ctrl
   import ebp_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   // axi4-lite write data
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   // axi4-lite write response
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   // transmit path: backplane in, line out
   input  wire logic              tx_bit_en,
   input  wire logic              tx_bp_data,
   output logic                   tx_line_data,
   // receive path: line in, backplane out
   input  wire logic              rx_bit_en,
   input  wire logic              rx_line_data,
   output logic                   rx_bp_data,
   // framer controls and interrupt
   output logic                   tx_framer_skip,
   output logic                   rx_framer_skip,
   output logic                   defect_detect_on,
   output logic                   irq
);

   // bus state
   logic              aw_have_q, aw_have_d;
   logic              w_have_q, w_have_d;
   logic [ADDR_W-1:0] waddr_q, waddr_d;
   logic [7:0]        wbyte_q, wbyte_d;
   logic              wlane_q, wlane_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q, bresp_d;
   logic              rvalid_q, rvalid_d;
   logic [1:0]        rresp_q, rresp_d;
   logic [31:0]       rdata_q, rdata_d;
   logic              wr_fire;
   logic [7:0]        wr_idx;

   // register state
   logic       swap_q, swap_d;
   logic       type_q, type_d;
   logic       inj_q, inj_d;
   logic       inv_q, inv_d;
   logic       chk_en_q, chk_en_d;
   logic       gen_en_q, gen_en_d;
   logic       rxbyp_q, rxbyp_d;
   logic       txbyp_q, txbyp_d;
   logic       defect_detect_on_q, defect_detect_on_d;
   logic [1:0] ist_q, ist_d;
   logic [1:0] imk_q, imk_d;
   logic       pend_q, pend_d;

   // datapath and lock state
   logic       tx_line_q, tx_line_d;
   logic       rx_bp_q, rx_bp_d;
   logic       lock_q, lock_d;
   logic [5:0] run_q, run_d;
   logic [2:0] errs_q, errs_d;

   // pattern engine signals
   logic gen_pred, chk_pred;
   logic gen_adv, chk_adv;
   logic gen_bit, chk_in;
   logic dir_chg;
   logic [1:0] ev;

   // handshake outputs are combinational from the holding flags
   assign awready = !aw_have_q && !bvalid_q;
   assign wready  = !w_have_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;

   // register write commits one cycle after both halves are held
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign wr_idx  = ebp_idx(waddr_q);

   // write channel: address and data taken in either order
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      waddr_d   = waddr_q;
      wbyte_d   = wbyte_q;
      wlane_d   = wlane_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (awvalid && awready) begin
         aw_have_d = 1'b1;
         waddr_d   = awaddr;
      end
      if (wvalid && wready) begin
         w_have_d = 1'b1;
         wbyte_d  = wdata[7:0];
         wlane_d  = wstrb[0];
      end
      if (wr_fire) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = ebp_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         waddr_q   <= '0;
         wbyte_q   <= 8'h00;
         wlane_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         waddr_q   <= waddr_d;
         wbyte_q   <= wbyte_d;
         wlane_q   <= wlane_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
      end
   end

   // read channel: answer one cycle after the address is taken
   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rresp_d  = ebp_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_d  = 32'h00000000;
         case (ebp_idx(araddr))
            IDX_SWAP: rdata_d[B_SWAP] = swap_q;
            IDX_PAT:  rdata_d[7:0] = {type_q, inj_q, inv_q,
                                      lock_q,
                                      chk_en_q, gen_en_q,
                                      rxbyp_q, txbyp_q};
            IDX_DDE:  rdata_d[B_DEFECT_DETECT_ON] = defect_detect_on_q;
            IDX_IST:  rdata_d[1:0] = ist_q;
            IDX_IMK:  rdata_d[1:0] = imk_q;
            default:  rdata_d = 32'h00000000; // loop-code, unmapped
         endcase
         if (!ebp_mapped(araddr)) begin
            rdata_d = 32'h00000000;
         end
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h00000000;
      end else begin
         rvalid_q <= rvalid_d;
         rresp_q  <= rresp_d;
         rdata_q  <= rdata_d;
      end
   end

   // software registers; only byte lane 0 carries fields
   always_comb begin
      swap_d   = swap_q;
      type_d   = type_q;
      inj_d    = inj_q;
      inv_d    = inv_q;
      chk_en_d = chk_en_q;
      gen_en_d = gen_en_q;
      rxbyp_d  = rxbyp_q;
      txbyp_d  = txbyp_q;
      defect_detect_on_d = defect_detect_on_q;
      imk_d    = imk_q;
      ist_d    = ist_q;
      pend_d   = pend_q;
      if (wr_fire && wlane_q) begin
         case (wr_idx)
            IDX_SWAP: swap_d = wbyte_q[B_SWAP];
            IDX_PAT: begin
               type_d   = wbyte_q[B_TYPE];
               inj_d    = wbyte_q[B_INJ];
               inv_d    = wbyte_q[B_INV];
               chk_en_d = wbyte_q[B_CHK];
               gen_en_d = wbyte_q[B_GEN];
               rxbyp_d  = wbyte_q[B_RXBYP];
               txbyp_d  = wbyte_q[B_TXBYP];
            end
            IDX_DDE: defect_detect_on_d = wbyte_q[B_DEFECT_DETECT_ON];
            IDX_IMK: imk_d = wbyte_q[1:0];
            IDX_IST: ist_d = ist_q & ~wbyte_q[1:0];
            default: ist_d = ist_q; // reserved: writes dropped
         endcase
      end
      // an event in the clearing cycle stays set
      ist_d = ist_d | ev;
      // consumed by the next generated bit; a new edge re-arms it
      if (gen_adv) begin
         pend_d = 1'b0;
      end
      if (!inj_q && inj_d && gen_en_d) begin
         pend_d = 1'b1;
      end
      if (!gen_en_d) begin
         pend_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swap_q   <= SWAP_RST[B_SWAP];
         type_q   <= PAT_RST[B_TYPE];
         inj_q    <= PAT_RST[B_INJ];
         inv_q    <= PAT_RST[B_INV];
         chk_en_q <= PAT_RST[B_CHK];
         gen_en_q <= PAT_RST[B_GEN];
         rxbyp_q  <= PAT_RST[B_RXBYP];
         txbyp_q  <= PAT_RST[B_TXBYP];
         defect_detect_on_q <= DDE_RST[B_DEFECT_DETECT_ON];
         ist_q    <= IRQ_RST;
         imk_q    <= IRQ_RST;
         pend_q   <= 1'b0;
      end else begin
         swap_q   <= swap_d;
         type_q   <= type_d;
         inj_q    <= inj_d;
         inv_q    <= inv_d;
         chk_en_q <= chk_en_d;
         gen_en_q <= gen_en_d;
         rxbyp_q  <= rxbyp_d;
         txbyp_q  <= txbyp_d;
         defect_detect_on_q <= defect_detect_on_d;
         ist_q    <= ist_d;
         imk_q    <= imk_d;
         pend_q   <= pend_d;
      end
   end

   // direction steering: swap moves generator to rx, checker to tx
   assign gen_adv = gen_en_q && (swap_q ? rx_bit_en : tx_bit_en);
   assign chk_adv = chk_en_q && (swap_q ? tx_bit_en : rx_bit_en);
   assign chk_in  = (swap_q ? tx_bp_data : rx_line_data) ^ inv_q;
   assign gen_bit = gen_pred ^ inv_q ^ pend_q;
   assign dir_chg = swap_d != swap_q;

   ebp_pat_lfsr u_gen (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .advance   (gen_adv),
      .qrts_sel  (type_q),
      .self_feed (1'b1),
      .in_bit    (1'b0),
      .pred_q    (gen_pred)
   );

   ebp_pat_lfsr u_chk (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .advance   (chk_adv),
      .qrts_sel  (type_q),
      .self_feed (1'b0),
      .in_bit    (chk_in),
      .pred_q    (chk_pred)
   );

   // outputs pass framer data unless the generator owns that side
   always_comb begin
      tx_line_d = tx_line_q;
      rx_bp_d   = rx_bp_q;
      if (tx_bit_en) begin
         tx_line_d = (gen_en_q && !swap_q) ? gen_bit : tx_bp_data;
      end
      if (rx_bit_en) begin
         rx_bp_d = (gen_en_q && swap_q) ? gen_bit : rx_line_data;
      end
   end

   // lock needs a clean run; a few errors while locked drop it
   always_comb begin
      lock_d = lock_q;
      run_d  = run_q;
      errs_d = errs_q;
      if (!chk_en_q || dir_chg) begin
         lock_d = 1'b0; // the active checker restarts from scratch
         run_d  = 6'h00;
         errs_d = 3'h0;
      end else if (chk_adv) begin
         if (chk_in != chk_pred) begin
            run_d = 6'h00;
            if (lock_q) begin
               errs_d = errs_q + 3'h1;
               if (errs_d == UNLOCK_ERRS) begin
                  lock_d = 1'b0;
                  errs_d = 3'h0;
               end
            end
         end else begin
            run_d = (run_q == LOCK_RUN) ? run_q : run_q + 6'h01;
            if (run_d == LOCK_RUN) begin
               lock_d = 1'b1;
               errs_d = 3'h0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_line_q <= 1'b0;
         rx_bp_q   <= 1'b0;
         lock_q    <= 1'b0;
         run_q     <= 6'h00;
         errs_q    <= 3'h0;
      end else begin
         tx_line_q <= tx_line_d;
         rx_bp_q   <= rx_bp_d;
         lock_q    <= lock_d;
         run_q     <= run_d;
         errs_q    <= errs_d;
      end
   end

   // lock gained and lost events feed the sticky status
   assign ev[B_EV_UP] = lock_d && !lock_q;
   assign ev[B_EV_DN] = !lock_d && lock_q;

   // outputs straight from their flops; irq gates sticky status with the mask
   assign tx_line_data     = tx_line_q;
   assign rx_bp_data       = rx_bp_q;
   assign tx_framer_skip   = txbyp_q;
   assign rx_framer_skip   = rxbyp_q;
   assign defect_detect_on = defect_detect_on_q;
   assign irq              = |(ist_q & imk_q);

endmodule : ebp_bert_ctrl
`default_nettype wire

/* rtl/ebp_pat_lfsr.sv */
// Purpose: shift-register pattern engine, used as generator or checker
// Assumes: advance is a one-cycle strobe per pattern bit
// Notes:   pred_q is always the next expected or emitted bit
`timescale 1ns/1ps
`default_nettype none
module ebp_pat_lfsr
   import ebp_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control
   input  wire logic advance,
   input  wire logic qrts_sel,
   input  wire logic self_feed,
   // data
   input  wire logic in_bit,
   output var  logic pred_q
);

   logic [LFSR_W-1:0] sr_q;
   logic [LFSR_W-1:0] sr_d;
   logic              pred_d;

   // feedback tap pair chosen by pattern type
   function automatic logic fb(input logic [LFSR_W-1:0] s,
                               input logic q);
      return q ? (s[QRS_TAP_A] ^ s[QRS_TAP_B])
               : (s[P15_TAP_A] ^ s[P15_TAP_B]);
   endfunction : fb

   // checker mode shifts in in_bit (line or backplane data) so it self-synchronises
   always_comb begin
      sr_d   = sr_q;
      pred_d = pred_q;
      if (advance) begin
         sr_d = {sr_q[LFSR_W-2:0], self_feed ? pred_q : in_bit};
         if (self_feed && (sr_d == '0)) begin
            sr_d = LFSR_SEED; // escape the all-zero lock-up state
         end
         pred_d = fb(sr_d, qrts_sel);
      end
   end

   // seed predicts zero for either tap pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sr_q   <= LFSR_SEED;
         pred_q <= 1'b0;
      end else begin
         sr_q   <= sr_d;
         pred_q <= pred_d;
      end
   end

endmodule : ebp_pat_lfsr
`default_nettype wire

/* rtl/ebp_pkg.sv */
// Purpose: constants for the per-channel pattern test control block
// Assumes: 32-bit AXI4-Lite, byte address = register index * 4
// Notes:   one channel; reserved loop-code registers read as zero
//
// Summary of operation
// - generator and checker direction comes from swap bit 3 of its own register.
// - read-only lock flag at bit 4, reset 0, high while checker synced.
// - swap off: receive-side checker drives the lock flag once synchronized.
// - checker on, swap off: check line receive data, flag lock on match.
// - checker on, swap on: check transmit backplane data, flag lock on match.
// - generator on, swap off: send pattern to line; clearing bit stops it.
// - generator on, swap on: send pattern on receive backplane instead.
// - receive framer bypass control at bit 1, reset 0.
// - transmit framer bypass control at bit 0, reset 0.
// - type bit 7: 0 selects fifteen-stage sequence, 1 quasi-random signal.
// - 0-to-1 of inject bit 6 flips one generated bit, only while generating.
// - invert bit 5 inverts generated data and checker input data.
package ebp_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SWAP = 8'h21;
   localparam logic [7:0] IDX_PAT  = 8'h23;
   localparam logic [7:0] IDX_LCC  = 8'h24;
   localparam logic [7:0] IDX_TLC  = 8'h25;
   localparam logic [7:0] IDX_RLA  = 8'h26;
   localparam logic [7:0] IDX_RLD  = 8'h27;
   localparam logic [7:0] IDX_DDE  = 8'h28;
   localparam logic [7:0] IDX_IST  = 8'h40;
   localparam logic [7:0] IDX_IMK  = 8'h41;

   // field positions
   localparam int B_SWAP   = 3;
   localparam int B_TYPE   = 7;
   localparam int B_INJ    = 6;
   localparam int B_INV    = 5;
   localparam int B_LOCK   = 4;
   localparam int B_CHK    = 3;
   localparam int B_GEN    = 2;
   localparam int B_RXBYP  = 1;
   localparam int B_TXBYP  = 0;
   localparam int B_DEFECT_DETECT_ON = 7;
   localparam int B_EV_UP  = 0;
   localparam int B_EV_DN  = 1;

   // reset values
   localparam logic [7:0] PAT_RST  = 8'h00;
   localparam logic [7:0] SWAP_RST = 8'h00;
   localparam logic [7:0] DDE_RST  = 8'h80;
   localparam logic [1:0] IRQ_RST  = 2'h0;

   // lock detector: matches to gain lock, errors to lose it
   localparam logic [5:0] LOCK_RUN    = 6'h28;
   localparam logic [2:0] UNLOCK_ERRS = 3'h4;

   // pattern engine
   localparam int          LFSR_W    = 20;
   localparam logic [19:0] LFSR_SEED = 20'h00001;
   localparam int          P15_TAP_A = 14;
   localparam int          P15_TAP_B = 13;
   localparam int          QRS_TAP_A = 19;
   localparam int          QRS_TAP_B = 16;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         ADDR_W      = 12;

   // register index from a byte address
   function automatic logic [7:0] ebp_idx(input logic [ADDR_W-1:0] a);
      return a[9:2];
   endfunction : ebp_idx

   // true for an address that lands on a register
   function automatic logic ebp_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[11:10] == 2'h0) &&
             ((i == IDX_SWAP) || ((i >= IDX_PAT) && (i <= IDX_DDE)) ||
              (i == IDX_IST) || (i == IDX_IMK));
   endfunction : ebp_mapped

endpackage : ebp_pkg
